// ### core/srgc_pkg.sv
package srgc_pkg;

    // Configuration-mode indices of the management interrupt registers
    localparam logic [7:0] IDX_WDT2 = 8'hB0;
    localparam logic [7:0] IDX_EN1 = 8'hB4;
    localparam logic [7:0] IDX_EN2 = 8'hB5;
    localparam logic [7:0] IDX_ST1 = 8'hB6;
    localparam logic [7:0] IDX_ST2 = 8'hB7;

    // Run-time window: index 08..0F maps onto B0..B7
    localparam logic [7:0] RT_FIRST = 8'h08;
    localparam logic [7:0] RT_LAST = 8'h0F;
    localparam logic [7:0] RT_OFFSET = 8'hA8;

    // Per-pin configuration bytes, one index per pin from this base
    localparam logic [7:0] GP_BASE = 8'hD0;
    localparam int GP_NUM_DEF = 16;

    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] GP_CFG_RST = 8'h01;

    // Writable / defined bits; reserved bits read as zero
    localparam logic [7:0] EN1_MASK = 8'hFE;
    localparam logic [7:0] EN2_MASK = 8'hD7;
    localparam logic [7:0] EN2_SRC_MASK = 8'h17;
    localparam logic [7:0] GP_CFG_MASK = 8'hDF;

    // Enable 1 / status 1 field positions
    localparam int B_PAR = 1;
    localparam int B_SER2 = 2;
    localparam int B_SER1 = 3;
    localparam int B_FLOP = 4;
    localparam int B_GRP2 = 5;
    localparam int B_GRP1 = 6;
    localparam int B_WDT = 7;

    // Enable 2 / status 2 field positions
    localparam int B_MOUSE = 0;
    localparam int B_KBD = 1;
    localparam int B_IR = 2;
    localparam int B_KBC = 4;
    localparam int B_FRAME = 6;
    localparam int B_PIN = 7;

    // Watchdog two: 250 ms units, zero stands for 256 units (64 s)
    localparam int WDT2_UNIT_MS = 250;
    localparam logic [8:0] WDT2_ZERO_UNITS = 9'h100;

    // Infrared edge detect arms once the synchroniser holds real samples
    localparam logic [1:0] IR_ARM_CYCLES = 2'h3;

    // Pin function select encodings
    localparam logic [1:0] FUNC_ORIG = 2'h0;
    localparam logic [1:0] FUNC_ALT1 = 2'h1;
    localparam logic [1:0] FUNC_ALT2 = 2'h2;
    localparam logic [1:0] FUNC_ALT3 = 2'h3;

    typedef struct packed {
        logic open_collector;
        logic int_en_two;
        logic reserved;
        logic [1:0] func_sel;
        logic int_en_one;
        logic invert;
        logic dir_in;
    } srgc_gp_cfg_t;

    typedef struct packed {
        logic mode;
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } srgc_cfg_req_t;

    typedef struct packed {
        logic watchdog;
        logic floppy;
        logic serial_one;
        logic serial_two;
        logic parallel;
        logic mouse;
        logic keyboard;
        logic kbc_line;
    } srgc_src_t;

endpackage : srgc_pkg

// ### core/srgc_sync.sv
`timescale 1ns/10ps
module srgc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : srgc_sync

// ### core/srgc_gp_pin.sv
`timescale 1ns/10ps
module srgc_gp_pin (
    input wire logic sys_clk,
    input wire logic rst_n,
    input srgc_pkg::srgc_gp_cfg_t cfg,
    input wire logic pad_in,
    input wire logic [3:0] func_out,
    output logic pad_out,
    output logic pad_oe,
    output logic level,
    output logic irq_one,
    output logic irq_two
);
    import srgc_pkg::*;

    logic drive_val;
    logic logic_in;
    logic oe_d;
    logic out_d;

    assign drive_val = func_out[cfg.func_sel] ^ cfg.invert;
    assign logic_in = pad_in ^ cfg.invert;
    // Open collector only ever pulls low; a high is left to the pull-up
    assign oe_d = !cfg.dir_in && (!cfg.open_collector || !drive_val);
    assign out_d = cfg.open_collector ? 1'b0 : drive_val;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            level <= 1'b0;
            irq_one <= 1'b0;
            irq_two <= 1'b0;
        end else begin
            pad_out <= out_d;
            pad_oe <= oe_d;
            level <= logic_in;
            irq_one <= logic_in && cfg.int_en_one;
            irq_two <= logic_in && cfg.int_en_two;
        end
    end
endmodule : srgc_gp_pin

// ### core/srgc_top.sv
// Contract
// - Watchdog two value counts 250 ms units; zero means 64 s, FF 63.75 s.
// - Enable one bits 1..7 pass parallel, UARTs, floppy, groups, watchdog to group.
// - Enable two bits 0,1,2 pass mouse, keyboard, infrared; bit 4 routes kbc line.
// - Enable two bit 6 places grouped interrupt in the serial IRQ frame.
// - Enable two bit 7 drives the dedicated pin; clear leaves it floating.
// - Status one bits 1..7 mirror their sources, cleared only at the source.
// - Status two bits 0, 1, 4 mirror mouse, keyboard, kbc line sources.
// - Status two bit 2 set by infrared edge after mux, cleared by read.
// - Timeout, enable and status registers also at indices 08..0F outside config mode.
// - Pin config bit 0: one makes the pin input, zero output.
// - Pin config bit 1 inverts the pin's logical value.
// - Pin config bit 2 includes the pin in combined interrupt one.
// - Pin config bit 6 includes the pin in combined interrupt two.
// - Pin config bits 4..3 select original or one of three alternate functions.
// - Pin config bit 7 makes an output open collector, else push-pull.
// - Infrared source is second UART receive, or alternate pin when mux bit set.
`timescale 1ns/10ps
module srgc_top #(
    parameter int GP_NUM = srgc_pkg::GP_NUM_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input srgc_pkg::srgc_cfg_req_t cfg_req,
    output logic [7:0] cfg_rdata,
    input srgc_pkg::srgc_src_t src,
    input wire logic ir_mux_alt,
    input wire logic serial_two_rx_pin,
    input wire logic alt_ir_rx_pin,
    input wire logic [GP_NUM-1:0] gp_pad_in,
    input wire logic [4*GP_NUM-1:0] gp_func_out,
    output logic [GP_NUM-1:0] gp_pad_out,
    output logic [GP_NUM-1:0] gp_pad_oe,
    output logic [GP_NUM-1:0] gp_level,
    output logic [7:0] watchdog_two_timeout,
    output logic [8:0] watchdog_two_units,
    output logic grouped_mgmt_irq_out_n,
    output logic grouped_mgmt_irq_oe,
    output logic serirq_mgmt_req
);
    import srgc_pkg::*;

    // Register hit: the index matches and the register window is open
    function automatic logic reg_hit(input logic open, input logic [7:0] idx, input logic [7:0] target);
        reg_hit = open && (idx == target);
    endfunction : reg_hit

    logic [7:0] wdt2_q;
    logic [7:0] en1_q;
    logic [7:0] en2_q;
    logic [7:0] st1_q;
    logic [7:0] st2_src_q;
    logic ir_flag_q;
    logic ir_flag_d;
    logic ir_prev_q;
    logic [1:0] ir_arm_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_n_q;
    logic irq_oe_q;
    logic frame_q;
    logic [8:0] units_q;

    srgc_gp_cfg_t gp_cfg_q [GP_NUM];
    logic [GP_NUM-1:0] gp_pad_sync;
    logic [GP_NUM-1:0] gp_irq_one;
    logic [GP_NUM-1:0] gp_irq_two;
    logic [GP_NUM-1:0] gp_hit;

    logic [1:0] ir_sync;
    logic ir_sel;
    logic ir_edge;
    logic rt_window;
    logic reg_open;
    logic [7:0] eff_idx;
    logic wr_wdt2;
    logic wr_en1;
    logic wr_en2;
    logic rd_st2;
    logic [7:0] st2_val;
    logic [7:0] st1_d;
    logic group_one;
    logic group_two;
    logic pending;

    // Index decode: config mode sees the full space, run-time only 08..0F
    assign rt_window = !cfg_req.mode && (cfg_req.index >= RT_FIRST) && (cfg_req.index <= RT_LAST);
    assign reg_open = cfg_req.mode || rt_window;
    assign eff_idx = rt_window ? 8'(cfg_req.index + RT_OFFSET) : cfg_req.index;

    assign wr_wdt2 = cfg_req.wr && reg_hit(reg_open, eff_idx, IDX_WDT2);
    assign wr_en1 = cfg_req.wr && reg_hit(reg_open, eff_idx, IDX_EN1);
    assign wr_en2 = cfg_req.wr && reg_hit(reg_open, eff_idx, IDX_EN2);
    assign rd_st2 = cfg_req.rd && reg_hit(reg_open, eff_idx, IDX_ST2);

    // Infrared receive: both candidate pins synchronised, then muxed
    srgc_sync #(
        .W(2)
    ) u_ir_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({serial_two_rx_pin, alt_ir_rx_pin}),
        .sync_out(ir_sync)
    );

    assign ir_sel = ir_mux_alt ? ir_sync[0] : ir_sync[1];
    // Flipping the mux between two unequal pins also counts as a transition
    assign ir_edge = (ir_arm_q == IR_ARM_CYCLES) && (ir_sel != ir_prev_q);
    // A new edge beats a clearing read in the same cycle
    assign ir_flag_d = ir_edge ? 1'b1 : (rd_st2 ? 1'b0 : ir_flag_q);

    // Pins
    srgc_sync #(
        .W(GP_NUM)
    ) u_gp_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(gp_pad_in),
        .sync_out(gp_pad_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < GP_NUM; gi++) begin : g_pin
            assign gp_hit[gi] = cfg_req.wr && reg_hit(cfg_req.mode, cfg_req.index, 8'(GP_BASE + gi));

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    gp_cfg_q[gi] <= srgc_gp_cfg_t'(GP_CFG_RST);
                end else if (gp_hit[gi]) begin
                    gp_cfg_q[gi] <= srgc_gp_cfg_t'(cfg_req.wdata & GP_CFG_MASK);
                end
            end

            srgc_gp_pin u_pin (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .cfg(gp_cfg_q[gi]),
                .pad_in(gp_pad_sync[gi]),
                .func_out(gp_func_out[4*gi +: 4]),
                .pad_out(gp_pad_out[gi]),
                .pad_oe(gp_pad_oe[gi]),
                .level(gp_level[gi]),
                .irq_one(gp_irq_one[gi]),
                .irq_two(gp_irq_two[gi])
            );
        end
    endgenerate

    assign group_one = |gp_irq_one;
    assign group_two = |gp_irq_two;

    // Status bits follow their sources; nothing here can clear them
    always_comb begin
        st1_d = REG_RST;
        st1_d[B_PAR] = src.parallel;
        st1_d[B_SER2] = src.serial_two;
        st1_d[B_SER1] = src.serial_one;
        st1_d[B_FLOP] = src.floppy;
        st1_d[B_GRP2] = group_two;
        st1_d[B_GRP1] = group_one;
        st1_d[B_WDT] = src.watchdog;
    end

    always_comb begin
        st2_val = st2_src_q;
        st2_val[B_IR] = ir_flag_q;
    end

    assign pending = |(st1_q & en1_q & EN1_MASK) || |(st2_val & en2_q & EN2_SRC_MASK);

    // Read mux; unmapped indices read zero
    always_comb begin
        rdata_d = rdata_q;
        if (cfg_req.rd) begin
            rdata_d = REG_RST;
            if (reg_open) begin
                unique case (eff_idx)
                    IDX_WDT2: rdata_d = wdt2_q;
                    IDX_EN1: rdata_d = en1_q;
                    IDX_EN2: rdata_d = en2_q;
                    IDX_ST1: rdata_d = st1_q;
                    IDX_ST2: rdata_d = st2_val;
                    default: rdata_d = REG_RST;
                endcase
            end
            for (int i = 0; i < GP_NUM; i++) begin
                if (reg_hit(cfg_req.mode, cfg_req.index, 8'(GP_BASE + i))) begin
                    rdata_d = gp_cfg_q[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt2_q <= REG_RST;
            en1_q <= REG_RST;
            en2_q <= REG_RST;
        end else begin
            if (wr_wdt2) begin
                wdt2_q <= cfg_req.wdata;
            end
            if (wr_en1) begin
                en1_q <= cfg_req.wdata & EN1_MASK;
            end
            if (wr_en2) begin
                en2_q <= cfg_req.wdata & EN2_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st1_q <= REG_RST;
            st2_src_q <= REG_RST;
        end else begin
            st1_q <= st1_d;
            st2_src_q <= {3'h0, src.kbc_line, 2'h0, src.keyboard, src.mouse};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_flag_q <= 1'b0;
            ir_prev_q <= 1'b0;
            ir_arm_q <= 2'h0;
        end else begin
            ir_flag_q <= ir_flag_d;
            ir_prev_q <= ir_sel;
            // Holds off edges until the synchroniser has flushed its reset zeros
            if (ir_arm_q != IR_ARM_CYCLES) begin
                ir_arm_q <= 2'(ir_arm_q + 2'h1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= REG_RST;
            irq_n_q <= 1'b1;
            irq_oe_q <= 1'b0;
            frame_q <= 1'b0;
            units_q <= WDT2_ZERO_UNITS;
        end else begin
            rdata_q <= rdata_d;
            irq_n_q <= !pending;
            irq_oe_q <= en2_q[B_PIN];
            frame_q <= pending && en2_q[B_FRAME];
            units_q <= (wdt2_q == REG_RST) ? WDT2_ZERO_UNITS : {1'b0, wdt2_q};
        end
    end

    assign cfg_rdata = rdata_q;
    assign watchdog_two_timeout = wdt2_q;
    assign watchdog_two_units = units_q;
    assign grouped_mgmt_irq_out_n = irq_n_q;
    assign grouped_mgmt_irq_oe = irq_oe_q;
    assign serirq_mgmt_req = frame_q;
endmodule : srgc_top

// ### verif/srgc_checker.sv
`timescale 1ns/10ps
module srgc_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input srgc_pkg::srgc_cfg_req_t cfg_req,
    input wire logic [7:0] cfg_rdata,
    input srgc_pkg::srgc_src_t src,
    input wire logic [7:0] watchdog_two_timeout,
    input wire logic [8:0] watchdog_two_units,
    input wire logic grouped_mgmt_irq_out_n,
    input wire logic grouped_mgmt_irq_oe,
    input wire logic serirq_mgmt_req
);
    import srgc_pkg::*;
    // Shadow enables, fed from both index spaces
    logic [7:0] en1_q;
    logic [7:0] en2_q;
    wire hit1 = cfg_req.mode ? (cfg_req.index == IDX_EN1) : (cfg_req.index == IDX_EN1 - RT_OFFSET);
    wire hit2 = cfg_req.mode ? (cfg_req.index == IDX_EN2) : (cfg_req.index == IDX_EN2 - RT_OFFSET);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en1_q <= REG_RST;
            en2_q <= REG_RST;
        end else begin
            if (cfg_req.wr && hit1) en1_q <= cfg_req.wdata & EN1_MASK;
            if (cfg_req.wr && hit2) en2_q <= cfg_req.wdata & EN2_MASK;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Units are registered from the timeout value, so they trail it by one cycle
    a_units_zero: assert property ($past(watchdog_two_timeout) == 8'h00
        |-> watchdog_two_units == WDT2_ZERO_UNITS)
        else $error("zero timeout not 256 units");
    a_units_binary: assert property ($past(watchdog_two_timeout) != 8'h00
        |-> watchdog_two_units == {1'b0, $past(watchdog_two_timeout)})
        else $error("timeout units wrong");
    a_en1_readback: assert property (cfg_req.rd && hit1 |=> cfg_rdata == $past(en1_q))
        else $error("enable one read back wrong");
    a_par_raise: assert property (src.parallel && en1_q[B_PAR] |-> ##2 !grouped_mgmt_irq_out_n)
        else $error("parallel source did not raise group");
    a_idle_high: assert property ((en1_q == 8'h00 && (en2_q & EN2_SRC_MASK) == 8'h00) [*2]
        |-> grouped_mgmt_irq_out_n)
        else $error("group active with all sources off");
    a_pin_enable: assert property (cfg_req.wr && hit2 |-> ##2 grouped_mgmt_irq_oe == en2_q[B_PIN])
        else $error("pin enable does not follow");
    a_frame_gate: assert property (!en2_q[B_FRAME] [*2] |-> !serirq_mgmt_req)
        else $error("frame request while frame disabled");
    a_frame_follow: assert property (serirq_mgmt_req |-> !grouped_mgmt_irq_out_n)
        else $error("frame request without group");
endmodule : srgc_checker

bind srgc_top srgc_checker srgc_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .src(src), .watchdog_two_timeout(watchdog_two_timeout),
    .watchdog_two_units(watchdog_two_units), .grouped_mgmt_irq_out_n(grouped_mgmt_irq_out_n),
    .grouped_mgmt_irq_oe(grouped_mgmt_irq_oe), .serirq_mgmt_req(serirq_mgmt_req));

// ### verif/srgc_host_model.sv
`timescale 1ns/10ps
module srgc_host_model (
    input wire logic grouped_mgmt_irq_out_n,
    input wire logic grouped_mgmt_irq_oe,
    input wire logic serirq_mgmt_req,
    output logic smi_seen
);
    // Board pull-up: a floating pin reads as no request
    wire line_level = grouped_mgmt_irq_oe ? grouped_mgmt_irq_out_n : 1'b1;
    assign smi_seen = !line_level || serirq_mgmt_req;
endmodule : srgc_host_model

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
    import srgc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    srgc_cfg_req_t cfg_req = '0;
    srgc_src_t src = '0;
    logic ir_mux_alt = 1'b0;
    logic serial_two_rx_pin = 1'b0;
    logic alt_ir_rx_pin = 1'b0;
    logic [15:0] gp_pad_in = '0;
    logic [63:0] gp_func_out = '0;
    logic [7:0] cfg_rdata;
    logic [15:0] gp_pad_out, gp_pad_oe, gp_level;
    logic [7:0] watchdog_two_timeout;
    logic [8:0] watchdog_two_units;
    logic grouped_mgmt_irq_out_n, grouped_mgmt_irq_oe, serirq_mgmt_req, smi_seen;
    int bad_count = 0;
    int checks_done = 0;
    always #2 sys_clk = ~sys_clk;
    srgc_top srgc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .src(src), .ir_mux_alt(ir_mux_alt), .serial_two_rx_pin(serial_two_rx_pin),
        .alt_ir_rx_pin(alt_ir_rx_pin), .gp_pad_in(gp_pad_in), .gp_func_out(gp_func_out),
        .gp_pad_out(gp_pad_out), .gp_pad_oe(gp_pad_oe), .gp_level(gp_level),
        .watchdog_two_timeout(watchdog_two_timeout), .watchdog_two_units(watchdog_two_units),
        .grouped_mgmt_irq_out_n(grouped_mgmt_irq_out_n), .grouped_mgmt_irq_oe(grouped_mgmt_irq_oe),
        .serirq_mgmt_req(serirq_mgmt_req));
    srgc_host_model srgc_host_model_i (.grouped_mgmt_irq_out_n(grouped_mgmt_irq_out_n),
        .grouped_mgmt_irq_oe(grouped_mgmt_irq_oe), .serirq_mgmt_req(serirq_mgmt_req), .smi_seen(smi_seen));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle strobe; caller never enters again in the same step
    task automatic acc(input logic w, input logic m, input logic [7:0] i, input logic [7:0] d);
        @(posedge sys_clk);
        cfg_req <= '{mode: m, wr: w, rd: !w, index: i, wdata: d};
        @(posedge sys_clk);
        cfg_req <= '{mode: m, wr: 1'b0, rd: 1'b0, index: i, wdata: d};
    endtask : acc
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic rdc(input logic m, input logic [7:0] i, input logic [7:0] exp);
        acc(1'b0, m, i, 8'h00);
        wt(1);
        chk(cfg_rdata, exp);
    endtask : rdc
    task automatic t_regs();
        chk(watchdog_two_units, 16'h0100);
        rdc(1, IDX_WDT2, 8'h00);
        acc(1, 1, IDX_EN1, 8'hFF);
        rdc(1, IDX_EN1, 8'hFE);
        acc(1, 1, IDX_EN2, 8'hFF);
        rdc(0, 8'h0D, 8'hD7);
        acc(1, 1, IDX_ST1, 8'hFF);
        rdc(0, 8'h0E, 8'h00);
        rdc(0, 8'h09, 8'h00);
        acc(1, 0, RT_FIRST, 8'hFF);
        wt(2);
        chk({watchdog_two_timeout, watchdog_two_units[7:0]}, 16'hFFFF);
        acc(1, 0, RT_FIRST, 8'h01);
        rdc(1, IDX_WDT2, 8'h01);
        chk(watchdog_two_units, 16'h0001);
        $display("register test done");
    endtask : t_regs
    task automatic t_src();
        logic [15:0] map [8] = '{16'h1000, 16'h0200, 16'h0100, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0080};
        acc(1, 1, IDX_EN2, 8'hD7);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk) src <= srgc_src_t'(8'h01 << i);
            rdc(1, IDX_ST1, map[i][7:0]);
            rdc(1, IDX_ST2, map[i][15:8]);
            chk({grouped_mgmt_irq_out_n, smi_seen}, 16'h0001);
            @(posedge sys_clk) src <= '0;
            wt(3);
            chk({grouped_mgmt_irq_out_n, smi_seen}, 16'h0002);
        end
        acc(1, 1, IDX_EN2, 8'h03);
        @(posedge sys_clk) src <= srgc_src_t'(8'h01);
        rdc(1, IDX_ST2, 8'h10);
        chk({grouped_mgmt_irq_out_n, grouped_mgmt_irq_oe, serirq_mgmt_req, smi_seen}, 16'h0008);
        acc(1, 1, IDX_EN2, 8'h50);
        wt(3);
        chk({grouped_mgmt_irq_out_n, grouped_mgmt_irq_oe, serirq_mgmt_req, smi_seen}, 16'h0003);
        @(posedge sys_clk) src <= '0;
        $display("source test done");
    endtask : t_src
    task automatic t_ir();
        @(posedge sys_clk) serial_two_rx_pin <= 1'b1;
        wt(5);
        rdc(0, RT_LAST, 8'h04);
        rdc(0, RT_LAST, 8'h00);
        @(posedge sys_clk) alt_ir_rx_pin <= 1'b1;
        wt(5);
        rdc(0, RT_LAST, 8'h00);
        @(posedge sys_clk) ir_mux_alt <= 1'b1;
        @(posedge sys_clk) alt_ir_rx_pin <= 1'b0;
        wt(5);
        rdc(0, RT_LAST, 8'h04);
        $display("infrared test done");
    endtask : t_ir
    task automatic t_gp();
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk) gp_func_out[3:0] <= 4'h1 << s;
            acc(1, 1, GP_BASE, 8'(s << 3));
            wt(3);
            chk({gp_pad_oe[0], gp_pad_out[0]}, 16'h0003);
        end
        acc(1, 1, GP_BASE, 8'h1A);
        wt(3);
        chk({gp_pad_oe[0], gp_pad_out[0]}, 16'h0002);
        acc(1, 1, GP_BASE, 8'h98);
        wt(3);
        chk({gp_pad_oe[0], gp_pad_out[0]}, 16'h0000);
        acc(1, 1, GP_BASE, 8'h45);
        @(posedge sys_clk) gp_pad_in[0] <= 1'b1;
        wt(6);
        chk({gp_pad_oe[0], gp_level[0]}, 16'h0001);
        rdc(1, IDX_ST1, 8'h60);
        acc(1, 1, GP_BASE, 8'h05);
        wt(6);
        rdc(1, IDX_ST1, 8'h40);
        acc(1, 1, GP_BASE, 8'h47);
        wt(6);
        chk(gp_level[0], 16'h0000);
        rdc(1, IDX_ST1, 8'h00);
        $display("pin test done");
    endtask : t_gp
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        wt(4);
        t_regs();
        t_src();
        t_ir();
        t_gp();
        tally_and_finish();
    end
    // All tests need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule : tb
